// File: hdl/dma_state_pkg.sv
/*
 Shared constants, types and helpers for the DMA free-buffer tally and
 transmit state register block.
 Assumes a 32-bit AXI4-Lite register bus and byte addressing.
*/
package dma_state_pkg;

   localparam int          ADDR_W     = 8;          // Register byte address width
   localparam int          DATA_W     = 32;         // Bus data width
   localparam int          TALLY_W    = 16;         // Free-buffer tally width
   localparam int          PTR_W      = 30;         // Descriptor pointer width
   localparam int          PTR_LSB    = 2;          // Pointer field low bit
   localparam int          RX_CH      = 3;          // Receive channels 1..3
   localparam int          FLAG_INPKT = 0;          // In-packet bit, words 0 and 1
   localparam int          FLAG_CUT   = 1;          // Early-cut bit, word 2

   // Register byte offsets
   localparam logic [7:0]  OFS_TALLY1 = 8'h00;
   localparam logic [7:0]  OFS_TALLY2 = 8'h04;
   localparam logic [7:0]  OFS_TALLY3 = 8'h08;
   localparam logic [7:0]  OFS_HEAD   = 8'h0c;
   localparam logic [7:0]  OFS_FIRST  = 8'h10;
   localparam logic [7:0]  OFS_ACTIVE = 8'h14;

   localparam logic [1:0]  RESP_OKAY  = 2'h0;       // Access done
   localparam logic [1:0]  RESP_SLVERR = 2'h2;      // Unmapped address

   localparam logic [15:0] TALLY_RST  = 16'h0000;   // Tally reset value
   localparam logic [29:0] PTR_RST    = 30'h00000000;
   localparam logic [31:0] WORD_ZERO  = 32'h00000000;

   // Transmit state as seen by the engine
   typedef struct packed {
      logic [PTR_W-1:0] send_queue_head_pointer;
      logic [PTR_W-1:0] packet_first_descriptor_pointer;
      logic [PTR_W-1:0] active_descriptor_pointer;
      logic             in_packet;
      logic             early_cut_flag;
   } tx_state_t;

   // Register select decoded from an address
   typedef enum {
      SEL_TALLY1, SEL_TALLY2, SEL_TALLY3, SEL_HEAD, SEL_FIRST, SEL_ACTIVE, SEL_NONE
   } reg_sel_t;

   // Byte-lane mask from write strobes
   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   // Address decode, used by both bus channels
   function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
      case (addr)
         OFS_TALLY1: decode = SEL_TALLY1;
         OFS_TALLY2: decode = SEL_TALLY2;
         OFS_TALLY3: decode = SEL_TALLY3;
         OFS_HEAD:   decode = SEL_HEAD;
         OFS_FIRST:  decode = SEL_FIRST;
         OFS_ACTIVE: decode = SEL_ACTIVE;
         default:    decode = SEL_NONE;
      endcase
   endfunction

endpackage

// File: hdl/free_buffer_tally.sv
/*
 One receive channel free-buffer tally.
 Software writes add to the tally; the engine takes one per buffer used.
 Assumes the take input is a one-cycle pulse per consumed buffer.
*/
`timescale 1ns/1ps
module free_buffer_tally
   import dma_state_pkg::*;
#(
   parameter int W = TALLY_W                // Tally width
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic         add_en,        // Software write this cycle
   input  wire logic [W-1:0] add_value,     // Lane-masked addend
   input  wire logic         take,          // Engine used one buffer
   output logic      [W-1:0] tally          // Current free-buffer count
);

   logic [W-1:0] next_tally;                // Next tally value

   // Add and take in the same cycle both count; wraps modulo 2**W
   always_comb begin
      next_tally = tally;
      if (add_en) begin
         next_tally = W'(next_tally + add_value);
      end
      if (take) begin
         next_tally = W'(next_tally - W'(1));
      end
   end

   // Register, frozen while the clock enable is low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tally <= W'(TALLY_RST);
      end else if (ce) begin
         tally <= next_tally;
      end
   end

endmodule

// File: hdl/tx_pointer_word.sv
/*
 One 30-bit descriptor pointer of the transmit state.
 Software writes merge per byte lane; an engine load replaces the value
 and wins over a software write in the same cycle.
 Assumes the pointer sits at bits 31..2 of its bus word.
*/
`timescale 1ns/1ps
module tx_pointer_word
   import dma_state_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic             sw_we,    // Software write strobe
   input  wire logic [31:0]      sw_data,  // Software write data
   input  wire logic [31:0]      sw_mask,  // Byte-lane mask
   input  wire logic             hw_load,  // Engine load strobe
   input  wire logic [PTR_W-1:0] hw_ptr,   // Engine pointer value
   output logic      [PTR_W-1:0] ptr       // Stored pointer
);

   logic [31:0]      merged;               // Old word merged with new lanes
   logic [PTR_W-1:0] next_ptr;             // Next pointer value

   // Engine first: it owns the pointer while walking the chain
   always_comb begin
      merged   = ({ptr, 2'h0} & ~sw_mask) | (sw_data & sw_mask);
      next_ptr = ptr;
      if (hw_load) begin
         next_ptr = hw_ptr;
      end else if (sw_we) begin
         next_ptr = merged[31:PTR_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ptr <= PTR_RST;
      end else if (ce) begin
         ptr <= next_ptr;
      end
   end

endmodule

// File: hdl/dma_buffer_tx_regs.sv
/*
 Receive free-buffer tallies for channels 1..3 and the first three
 transmit state words of the packet DMA engine, behind an AXI4-Lite slave.
 Assumes the engine pulses rx_take per consumed buffer and tx_load when
 it moves to a new state; all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
module dma_buffer_tx_regs
   import dma_state_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic [RX_CH-1:0]      rx_take,
   input  wire logic                  tx_load,
   input  wire tx_state_t             tx_in,
   output logic [RX_CH-1:0][TALLY_W-1:0] rx_tally,
   output tx_state_t                  tx_state
);

   // Write channel holding registers
   logic              aw_held;             // Address taken, awaiting write
   logic [ADDR_W-1:0] aw_addr;             // Held write address
   logic              w_held;              // Data taken, awaiting write
   logic [31:0]       w_data;              // Held write data
   logic [3:0]        w_strb;              // Held strobes
   logic              next_aw_held;
   logic [ADDR_W-1:0] next_aw_addr;
   logic              next_w_held;
   logic [31:0]       next_w_data;
   logic [3:0]        next_w_strb;
   logic              next_bvalid;
   logic [1:0]        next_bresp;
   logic              do_write;            // Write performed this cycle
   reg_sel_t          wr_sel;              // Decoded write target
   logic [31:0]       wmask;               // Byte-lane mask

   // Read channel registers
   logic              next_rvalid;
   logic [31:0]       next_rdata;
   logic [1:0]        next_rresp;
   reg_sel_t          rd_sel;              // Decoded read target
   reg_sel_t          rd_last;             // Target of the data on the bus
   reg_sel_t          next_rd_last;

   // Flag state
   logic              in_pkt;
   logic              cut;
   logic              next_in_pkt;
   logic              next_cut;

   logic [PTR_W-1:0]  head_ptr;
   logic [PTR_W-1:0]  first_ptr;
   logic [PTR_W-1:0]  active_ptr;

   // Each ready only while its own channel holds nothing and no response pends; ce stalls all
   assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
   assign s_axi_arready = ce && !s_axi_rvalid;

   assign do_write = ce && aw_held && w_held && !s_axi_bvalid;
   assign wr_sel   = decode(aw_addr);
   assign rd_sel   = decode(s_axi_araddr);
   assign wmask    = strb_mask(w_strb);

   // Write channel: address and data may arrive in either order
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aw_held      <= 1'b0;
         aw_addr      <= '0;
         w_held       <= 1'b0;
         w_data       <= WORD_ZERO;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (ce) begin
         aw_held      <= next_aw_held;
         aw_addr      <= next_aw_addr;
         w_held       <= next_w_held;
         w_data       <= next_w_data;
         w_strb       <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp  <= next_bresp;
      end
   end

   // Receive tallies, one counter per channel
   for (genvar ch = 0; ch < RX_CH; ch++) begin : g_tally
      free_buffer_tally #(
         .W         (TALLY_W)
      ) u_tally (
         .clk       (clk),
         .rst_n     (rst_n),
         .ce        (ce),
         .add_en    (do_write && (wr_sel == reg_sel_t'(ch))),
         .add_value (w_data[TALLY_W-1:0] & wmask[TALLY_W-1:0]),
         .take      (rx_take[ch]),
         .tally     (rx_tally[ch])
      );
   end

   // Transmit pointers
   tx_pointer_word u_head (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .sw_we   (do_write && (wr_sel == SEL_HEAD)),
      .sw_data (w_data),
      .sw_mask (wmask),
      .hw_load (tx_load),
      .hw_ptr  (tx_in.send_queue_head_pointer),
      .ptr     (head_ptr)
   );

   tx_pointer_word u_first (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .sw_we   (do_write && (wr_sel == SEL_FIRST)),
      .sw_data (w_data),
      .sw_mask (wmask),
      .hw_load (tx_load),
      .hw_ptr  (tx_in.packet_first_descriptor_pointer),
      .ptr     (first_ptr)
   );

   tx_pointer_word u_active (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .sw_we   (do_write && (wr_sel == SEL_ACTIVE)),
      .sw_data (w_data),
      .sw_mask (wmask),
      .hw_load (tx_load),
      .hw_ptr  (tx_in.active_descriptor_pointer),
      .ptr     (active_ptr)
   );

   // Flags: in-packet is one bit shared by words 0 and 1; an engine load
   // wins over software, so a hardware-set cut is never lost to a clear
   always_comb begin
      next_in_pkt = in_pkt;
      next_cut    = cut;
      if (tx_load) begin
         next_in_pkt = tx_in.in_packet;
         next_cut    = tx_in.early_cut_flag;
      end else if (do_write) begin
         if ((wr_sel == SEL_HEAD || wr_sel == SEL_FIRST) && w_strb[0]) begin
            next_in_pkt = w_data[FLAG_INPKT];
         end
         if (wr_sel == SEL_ACTIVE && w_strb[0]) begin
            next_cut = w_data[FLAG_CUT];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         in_pkt <= 1'b0;
         cut    <= 1'b0;
      end else if (ce) begin
         in_pkt <= next_in_pkt;
         cut    <= next_cut;
      end
   end

   assign tx_state = '{send_queue_head_pointer:         head_ptr,
                       packet_first_descriptor_pointer: first_ptr,
                       active_descriptor_pointer:       active_ptr,
                       in_packet:                       in_pkt,
                       early_cut_flag:                  cut};

   // Read channel: data registered one cycle after the address is taken
   always_comb begin
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      next_rd_last = rd_last;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid  = 1'b1;
         next_rresp   = RESP_OKAY;
         next_rd_last = rd_sel;
         next_rdata   = WORD_ZERO;
         case (rd_sel)
            SEL_TALLY1: next_rdata[TALLY_W-1:0] = rx_tally[0];
            SEL_TALLY2: next_rdata[TALLY_W-1:0] = rx_tally[1];
            SEL_TALLY3: next_rdata[TALLY_W-1:0] = rx_tally[2];
            SEL_HEAD: begin
               next_rdata[31:PTR_LSB]   = head_ptr;
               next_rdata[FLAG_INPKT]   = in_pkt;
            end
            SEL_FIRST: begin
               next_rdata[31:PTR_LSB]   = first_ptr;
               next_rdata[FLAG_INPKT]   = in_pkt;
            end
            SEL_ACTIVE: begin
               next_rdata[31:PTR_LSB]   = active_ptr;
               next_rdata[FLAG_CUT]     = cut;
            end
            default: next_rresp = RESP_SLVERR;   // Unmapped reads zero
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= WORD_ZERO;
         s_axi_rresp  <= RESP_OKAY;
         rd_last      <= SEL_NONE;
      end else if (ce) begin
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rresp;
         rd_last      <= next_rd_last;
      end
   end

   // Checks
   sequence both_held_s;
      aw_held && w_held && !s_axi_bvalid && ce;
   endsequence

   sequence resp_up_s;
      s_axi_bvalid;
   endsequence

   write_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
      both_held_s |=> resp_up_s)
      else $error("write response missing after write");

   bvalid_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");

   tally_add_a: assert property (@(posedge clk) disable iff (!rst_n)
      do_write && wr_sel == SEL_TALLY1 && w_strb == 4'hf && !rx_take[0]
      |=> rx_tally[0] == TALLY_W'($past(rx_tally[0]) + $past(w_data[TALLY_W-1:0])))
      else $error("tally write did not add");

   tally_take_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && rx_take[1] && !(do_write && wr_sel == SEL_TALLY2)
      |=> rx_tally[1] == TALLY_W'($past(rx_tally[1]) - TALLY_W'(1)))
      else $error("tally did not drop by one");

   tally_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_axi_rvalid && rd_last inside {SEL_TALLY1, SEL_TALLY2, SEL_TALLY3}
      |-> s_axi_rdata[31:TALLY_W] == '0)
      else $error("tally upper bits not zero");

   head_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && tx_load |=> head_ptr == $past(tx_in.send_queue_head_pointer))
      else $error("queue head not loaded");

   first_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_axi_arvalid && s_axi_arready && rd_sel == SEL_FIRST
      |=> s_axi_rvalid && s_axi_rdata[31:PTR_LSB] == $past(first_ptr))
      else $error("packet start pointer misread");

   active_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_axi_arvalid && s_axi_arready && rd_sel == SEL_ACTIVE
      |=> s_axi_rdata[31:PTR_LSB] == $past(active_ptr))
      else $error("active pointer misread");

   inpkt_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_axi_arvalid && s_axi_arready && rd_sel == SEL_HEAD
      |=> !s_axi_rdata[FLAG_CUT] && s_axi_rdata[FLAG_INPKT] == $past(in_pkt))
      else $error("word 0 flag bits wrong");

   cut_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_axi_rvalid && rd_last == SEL_ACTIVE |-> !s_axi_rdata[FLAG_INPKT])
      else $error("word 2 bit 0 not zero");

   cut_set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && tx_load && tx_in.early_cut_flag |=> cut)
      else $error("engine cut lost to write");

endmodule

// File: testbench/engine_model.sv
/*
 Engine side model: consumes receive buffers and loads transmit state.
 Assumes the bench sets requests just after a rising clock edge.
*/
`timescale 1ns/1ps
module engine_model
   import dma_state_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [RX_CH-1:0] req_take,  // Channels to consume from
   input  wire logic             req_load,  // Load a new state
   input  wire tx_state_t        req_state, // State to load
   output logic      [RX_CH-1:0] rx_take,   // One pulse per request cycle
   output logic                  tx_load,   // Load strobe
   output tx_state_t             tx_in      // New state, valid with tx_load
);
   // Outside a load the state bus toggles, so a stale value never passes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_take <= '0;
         tx_load <= 1'b0;
         tx_in   <= '0;
      end else begin
         rx_take <= req_take;
         tx_load <= req_load;
         tx_in   <= req_load ? req_state : ~tx_in;
      end
   end
endmodule

// File: testbench/tb_top.sv
/*
 Self-checking bench for the tally and transmit state register block.
 Assumes the AXI4-Lite slave and the engine model share one clock.
*/
`timescale 1ns/1ps
module tb_top
   import dma_state_pkg::*;
;
   logic                        clk;
   logic                        rst_n;
   logic [ADDR_W-1:0]           awaddr;
   logic                        awvalid;
   logic                        awready;
   logic [31:0]                 wdata;
   logic [3:0]                  wstrb;
   logic                        wvalid;
   logic                        wready;
   logic [1:0]                  bresp;
   logic                        bvalid;
   logic                        bready;
   logic [ADDR_W-1:0]           araddr;
   logic                        arvalid;
   logic                        arready;
   logic [31:0]                 rdata;
   logic [1:0]                  rresp;
   logic                        rvalid;
   logic                        rready;
   logic [RX_CH-1:0]            rx_take;
   logic                        tx_load;
   tx_state_t                   tx_in;
   logic [RX_CH-1:0][TALLY_W-1:0] rx_tally;
   tx_state_t                   tx_state;
   logic [RX_CH-1:0]            req_take;  // Engine requests
   logic                        req_load;
   tx_state_t                   req_state;
   int                          n_fail;    // Mismatches
   int                          n_tests;   // Comparisons
   logic                        ce;        // Clock enable of the block
   logic [31:0]                 rd;
   logic [1:0]                  rsp;
   tx_state_t                   s;

   dma_buffer_tx_regs i_dma_buffer_tx_regs (
      .clk(clk), .rst_n(rst_n), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_take(rx_take),
      .tx_load(tx_load), .tx_in(tx_in), .rx_tally(rx_tally), .tx_state(tx_state));

   engine_model i_engine_model (
      .clk(clk), .rst_n(rst_n), .req_take(req_take), .req_load(req_load),
      .req_state(req_state), .rx_take(rx_take), .tx_load(tx_load), .tx_in(tx_in));

   // Clock at 200 MHz
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Counts and verdict, the only exit
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Hang limit, far above the hundred or so cycles the tests need
   localparam int HANG_LIMIT = 5000;

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Write: offer address and data together, release each once taken
   task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] st, logic [1:0] er);
      logic aw_hit, w_hit, b_hit, aw_done, w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= st;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(negedge clk);
         aw_hit = awvalid & awready;
         w_hit  = wvalid & wready;
         @(posedge clk);
         if (aw_hit) begin
            awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (w_hit) begin
            wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end
      do begin
         @(negedge clk);
         b_hit = bvalid;
         rsp   = bresp;
         @(posedge clk);
      end while (!b_hit);
      chk("bresp", {30'h0, er}, {30'h0, rsp});
   endtask

   // Read one word and compare data and response
   task automatic rdc(string nm, logic [7:0] a, logic [31:0] e, logic [1:0] er);
      logic hit;
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge clk);
         hit = arready;
         @(posedge clk);
      end while (!hit);
      arvalid <= 1'b0;
      do begin
         @(negedge clk);
         hit = rvalid;
         rd  = rdata;
         rsp = rresp;
         @(posedge clk);
      end while (!hit);
      chk(nm, e, rd);
      chk("rresp", {30'h0, er}, {30'h0, rsp});
   endtask

   // Engine consumes from channels in mask for n back-to-back cycles
   task automatic take(logic [2:0] m, int n);
      req_take <= m;
      repeat (n) @(posedge clk);
      req_take <= '0;
      repeat (2) @(posedge clk);
   endtask

   task automatic load(tx_state_t v);
      req_load  <= 1'b1;
      req_state <= v;
      @(posedge clk);
      req_load <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // Main sequence; a task, so that the hang limit races it in one process
   task automatic run_tests();
      rst_n = 1'b0;
      {awaddr, awvalid, wdata, wstrb, wvalid} = '0;
      {araddr, arvalid, req_take, req_load} = '0;
      // Responses are always accepted at once, so the ready lines never toggle
      {bready, rready, ce} = 3'h7;
      req_state = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Reset values of all six words
      for (int i = 0; i < 6; i++) begin
         rdc("reset word", 8'(4 * i), 32'h0, RESP_OKAY);
      end
      // Writes add on every channel; upper half ignored and reads zero
      for (int c = 0; c < 3; c++) begin
         wr(8'(4 * c), 32'hffff1234, 4'hf, RESP_OKAY);
         wr(8'(4 * c), 32'h00000001, 4'hf, RESP_OKAY);
         rdc("tally sum", 8'(4 * c), 32'h00001235, RESP_OKAY);
      end
      // Two back-to-back takes on channel 1 only
      take(3'h1, 2);
      rdc("tally ch1", OFS_TALLY1, 32'h00001233, RESP_OKAY);
      rdc("tally ch2", OFS_TALLY2, 32'h00001235, RESP_OKAY);
      take(3'h6, 1);
      chk("port ch3", 32'h00001234, {16'h0, rx_tally[2]});
      chk("port ch1", 32'h00001233, {16'h0, rx_tally[0]});
      // Clock enable low: a take seen while frozen leaves the tally alone
      ce <= 1'b0;
      take(3'h4, 1);
      ce <= 1'b1;
      chk("frozen ch3", 32'h00001234, {16'h0, rx_tally[2]});
      // Engine state in packet with early cut
      s = '{30'h12345678, 30'h0abcdef1, 30'h3fffffff, 1'b1, 1'b1};
      load(s);
      chk("state flags", 32'h3, {30'h0, tx_state.in_packet, tx_state.early_cut_flag});
      rdc("head word", OFS_HEAD, {30'h12345678, 2'b01}, RESP_OKAY);
      rdc("first word", OFS_FIRST, {30'h0abcdef1, 2'b01}, RESP_OKAY);
      rdc("active word", OFS_ACTIVE, {30'h3fffffff, 2'b10}, RESP_OKAY);
      s = '{30'h00000001, 30'h20000000, 30'h15555555, 1'b0, 1'b0};
      load(s);
      chk("state port", 32'h15555555, {2'b0, tx_state.active_descriptor_pointer});
      rdc("head idle", OFS_HEAD, {30'h00000001, 2'b00}, RESP_OKAY);
      rdc("active idle", OFS_ACTIVE, {30'h15555555, 2'b00}, RESP_OKAY);
      // Reserved bits stay zero under an all-ones write
      wr(OFS_HEAD, 32'hffffffff, 4'hf, RESP_OKAY);
      rdc("head ones", OFS_HEAD, 32'hfffffffd, RESP_OKAY);
      rdc("first flag", OFS_FIRST, {30'h20000000, 2'b01}, RESP_OKAY);
      wr(OFS_ACTIVE, 32'hffffffff, 4'hf, RESP_OKAY);
      rdc("active ones", OFS_ACTIVE, 32'hfffffffe, RESP_OKAY);
      // Unmapped place: write ignored, read zero, both refused
      wr(8'h18, 32'hffffffff, 4'hf, RESP_SLVERR);
      rdc("unmapped", 8'h18, 32'h0, RESP_SLVERR);
      rdc("tally kept", OFS_TALLY3, 32'h00001234, RESP_OKAY);
   endtask

   // Tests race the hang limit; whichever ends first leads to the verdict
   initial begin
      n_fail  = 0;
      n_tests = 0;
      fork
         run_tests();
         begin
            repeat (HANG_LIMIT) @(posedge clk);
            n_fail++;
            $display("mismatch run_length expected below %0d seen %0d", HANG_LIMIT, HANG_LIMIT);
         end
      join_any
      report_and_stop();
   end
endmodule
